// >>> drtw_pkg.sv
// ==========================================================
// register map and field layout
package drtw_pkg;
	localparam int          DRTW_AW          = 16;
	localparam int          DRTW_DW          = 8;
	localparam logic [15:0] DRTW_OFS_CTRL    = 16'h0108;
	localparam logic [15:0] DRTW_OFS_ONESHOT = 16'h0109;
	localparam logic [15:0] DRTW_OFS_IOCTL   = 16'h010A;
	localparam logic [15:0] DRTW_OFS_MODE    = 16'h010B;
	localparam logic [15:0] DRTW_OFS_PRE     = 16'h010C;
	localparam logic [15:0] DRTW_OFS_SEC     = 16'h010D;
	localparam logic [15:0] DRTW_OFS_PRI     = 16'h010E;

	// ==========================================================
	// control register fields
	localparam int          DRTW_CTRL_RUN    = 0;
	localparam int          DRTW_CTRL_STAT   = 1;
	localparam int          DRTW_CTRL_HALT   = 2;

	// ==========================================================
	// io control fields
	localparam int          DRTW_IO_OLS      = 0;
	localparam int          DRTW_IO_OSS      = 1;
	localparam logic [3:0]  DRTW_IO_MASK     = 4'hF;

	// ==========================================================
	// mode register fields
	localparam int          DRTW_MODE_LSB    = 0;
	localparam int          DRTW_MODE_WTS    = 3;
	localparam int          DRTW_SRC_LSB     = 4;
	localparam logic [1:0]  DRTW_MODE_TIMER  = 2'h0;
	localparam logic [1:0]  DRTW_MODE_WAVE   = 2'h1;
	localparam logic [1:0]  DRTW_SRC_F1      = 2'h0;
	localparam logic [1:0]  DRTW_SRC_F8      = 2'h1;
	localparam logic [1:0]  DRTW_SRC_UP      = 2'h2;
	localparam logic [1:0]  DRTW_SRC_F2      = 2'h3;
	localparam logic [2:0]  DRTW_DIV8_LAST   = 3'h7;

	// ==========================================================
	// reset values
	localparam logic [7:0]  DRTW_RST_BYTE    = 8'h00;
	localparam logic [7:0]  DRTW_RST_RELOAD  = 8'hFF;

	// ==========================================================
	// count states
	typedef enum logic [1:0] {
		DRTW_IDLE      = 2'h0,
		DRTW_PRIMARY   = 2'h1,
		DRTW_SECONDARY = 2'h3
	} drtw_state_t;
endpackage : drtw_pkg

// >>> drtw_timer.sv
// The plain strobed port was decided locally.
`timescale 1ns/1ps
// Contract
// - prescaler and timer, each reload plus counter
// - write target bit picks counter and reload, or reload only
// - prescaler transfer only on count source edge
// - timer transfer only on prescaler underflow
// - counter write lands at next transfer
// - reload-only writes shift with prescaler value
// - io control bits four to seven read zero
// - waveform pin inverts on each timer underflow
// - first waveform period is the primary one
// - waveform mode ignores one-shot control register
// - count source f1, f2, f8 or upstream
// - decrement, reload primary and secondary alternately
// - periods are (n+1)(m+1) and (n+1)(p+1)
// - writing run bit one with halt zero starts counting
// - run zero or halt one stops counting
// - irq with pin change after secondary underflow
// - primary and prescaler reads give live count
// - stopped writes load both, running reload only in waveform mode or with write target bit one
// - running writes show from next primary period after a primary write
// - source switch picks waveform or port latch
// - source switch latched at start or irq
// - level select sets primary, secondary, stopped levels
// - switch zero waveform, one port latch
module drtw_timer
	import drtw_pkg::*;
(
	input  wire logic                 core_clk,
	input  wire logic                 nrst,
	input  wire logic [DRTW_AW-1:0]   addr,
	input  wire logic [DRTW_DW-1:0]   wdata,
	input  wire logic                 wr_en,
	input  wire logic                 rd_en,
	output logic      [DRTW_DW-1:0]   rdata,
	input  wire logic                 upstream_uf,
	input  wire logic                 port_output_latch,
	output logic                      waveform_output_pin,
	output logic                      waveform_output_oe,
	output logic                      timer_irq,
	output logic                      counting
);

	// ==========================================================
	// state and registers
	drtw_state_t  state_q, state_d;
	logic [7:0]   io_q;
	logic [7:0]   mode_q;
	logic [7:0]   pre_rld_q, pre_cnt_q;
	logic [7:0]   pri_rld_q, sec_rld_q, tmr_cnt_q;
	logic [7:0]   pre_buf_q, pri_buf_q, sec_buf_q;
	logic         commit_q;
	logic         pre_pend_q, tmr_pend_q;
	logic [2:0]   div_q;
	logic         wave_q;
	logic         oss_q;
	logic         irq_q;
	logic [7:0]   rdata_q;

	// ==========================================================
	// address decode
	wire          sel_ctrl  = (addr == DRTW_OFS_CTRL);
	wire          sel_io    = (addr == DRTW_OFS_IOCTL);
	wire          sel_mode  = (addr == DRTW_OFS_MODE);
	wire          sel_pre   = (addr == DRTW_OFS_PRE);
	wire          sel_sec   = (addr == DRTW_OFS_SEC);
	wire          sel_pri   = (addr == DRTW_OFS_PRI);
	wire          wr_ctrl   = wr_en & sel_ctrl;
	wire          wr_io     = wr_en & sel_io;
	wire          wr_mode   = wr_en & sel_mode;
	wire          wr_pre    = wr_en & sel_pre;
	wire          wr_sec    = wr_en & sel_sec;
	wire          wr_pri    = wr_en & sel_pri;

	// ==========================================================
	// mode fields
	wire [1:0]    mode_sel  = mode_q[DRTW_MODE_LSB +: 2];
	wire [1:0]    src_sel   = mode_q[DRTW_SRC_LSB +: 2];
	wire          wts       = mode_q[DRTW_MODE_WTS];
	wire          is_wave   = (mode_sel == DRTW_MODE_WAVE);
	wire          ols       = io_q[DRTW_IO_OLS];
	wire          running   = (state_q != DRTW_IDLE);
	wire          in_sec    = (state_q == DRTW_SECONDARY);

	// ==========================================================
	// run control
	wire          halt_wr   = wr_ctrl & wdata[DRTW_CTRL_HALT];
	wire          run_wr    = wr_ctrl & ~wdata[DRTW_CTRL_HALT];
	wire          start     = run_wr & wdata[DRTW_CTRL_RUN] & ~running;
	wire          stop      = halt_wr | (run_wr & ~wdata[DRTW_CTRL_RUN]);

	// ==========================================================
	// count source selection
	wire          en_f2     = div_q[0];
	wire          en_f8     = (div_q == DRTW_DIV8_LAST);
	wire          src_en    = (src_sel == DRTW_SRC_F1) ? 1'b1 :
	                          (src_sel == DRTW_SRC_F2) ? en_f2 :
	                          (src_sel == DRTW_SRC_F8) ? en_f8 : upstream_uf;
	wire          ce        = running & src_en;

	// ==========================================================
	// underflow detection
	wire          pre_uf    = ce & (pre_cnt_q == 8'h00) & ~pre_pend_q;
	wire          pre_step  = ce;
	wire          tmr_step  = pre_uf;
	wire          tmr_uf    = tmr_step & (tmr_cnt_q == 8'h00) & ~tmr_pend_q;
	wire          sec_end   = tmr_uf & is_wave & in_sec;
	wire          irq_ev    = is_wave ? sec_end : tmr_uf;

	// ==========================================================
	// write routing
	wire          wave_run  = running & is_wave;
	wire          direct    = ~running;
	wire          tm_both   = running & ~is_wave & ~wts;
	wire          to_rld    = ~wave_run;
	wire          to_buf    = wave_run;
	wire          do_commit = sec_end & commit_q;

	// ==========================================================
	// reload values
	wire [7:0]    pre_rld_n = do_commit ? pre_buf_q : pre_rld_q;
	wire [7:0]    pri_rld_n = do_commit ? pri_buf_q : pri_rld_q;
	wire [7:0]    sec_rld_n = do_commit ? sec_buf_q : sec_rld_q;
	wire [7:0]    tmr_rld   = (is_wave & ~in_sec) ? sec_rld_n : pri_rld_n;

	// ==========================================================
	// next state
	always_comb begin
		state_d = state_q;
		case (state_q)
			DRTW_IDLE: begin
				if (start) begin
					state_d = DRTW_PRIMARY;
				end
			end
			DRTW_PRIMARY: begin
				if (stop) begin
					state_d = DRTW_IDLE;
				end else if (tmr_uf & is_wave) begin
					state_d = DRTW_SECONDARY;
				end
			end
			DRTW_SECONDARY: begin
				if (stop) begin
					state_d = DRTW_IDLE;
				end else if (tmr_uf | ~is_wave) begin
					state_d = DRTW_PRIMARY;
				end
			end
			default: begin
				state_d = DRTW_IDLE;
			end
		endcase
	end

	// ==========================================================
	// state register and divider
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= DRTW_IDLE;
			div_q   <= 3'h0;
		end else begin
			state_q <= state_d;
			div_q   <= div_q + 3'h1;
		end
	end

	// ==========================================================
	// configuration registers
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			io_q   <= DRTW_RST_BYTE;
			mode_q <= DRTW_RST_BYTE;
		end else begin
			if (wr_io) begin
				io_q <= {4'h0, wdata[3:0] & DRTW_IO_MASK};
			end
			if (wr_mode) begin
				mode_q <= wdata;
			end
		end
	end

	// ==========================================================
	// prescaler reload register
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			pre_rld_q <= DRTW_RST_RELOAD;
		end else if (wr_pre & to_rld) begin
			pre_rld_q <= wdata;
		end else if (do_commit) begin
			pre_rld_q <= pre_buf_q;
		end
	end

	// ==========================================================
	// timer reload registers
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			pri_rld_q <= DRTW_RST_RELOAD;
			sec_rld_q <= DRTW_RST_RELOAD;
		end else begin
			if (wr_pri & to_rld) begin
				pri_rld_q <= wdata;
			end else if (do_commit) begin
				pri_rld_q <= pri_buf_q;
			end
			if (wr_sec & to_rld) begin
				sec_rld_q <= wdata;
			end else if (do_commit) begin
				sec_rld_q <= sec_buf_q;
			end
		end
	end

	// ==========================================================
	// staging for writes made while the waveform runs
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			pre_buf_q <= DRTW_RST_RELOAD;
			pri_buf_q <= DRTW_RST_RELOAD;
			sec_buf_q <= DRTW_RST_RELOAD;
			commit_q  <= 1'b0;
		end else begin
			pre_buf_q <= (wr_pre & to_buf) ? wdata : (to_buf ? pre_buf_q : pre_rld_n);
			sec_buf_q <= (wr_sec & to_buf) ? wdata : (to_buf ? sec_buf_q : sec_rld_n);
			pri_buf_q <= (wr_pri & to_buf) ? wdata : (to_buf ? pri_buf_q : pri_rld_n);
			if (wr_pri & to_buf) begin
				commit_q <= 1'b1;
			end else if (do_commit | ~wave_run) begin
				commit_q <= 1'b0;
			end
		end
	end

	// ==========================================================
	// pending counter writes in timer mode
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			pre_pend_q <= 1'b0;
			tmr_pend_q <= 1'b0;
		end else begin
			if (wr_pre & tm_both) begin
				pre_pend_q <= 1'b1;
			end else if (pre_step | ~running) begin
				pre_pend_q <= 1'b0;
			end
			if (wr_pri & tm_both) begin
				tmr_pend_q <= 1'b1;
			end else if (tmr_step | ~running) begin
				tmr_pend_q <= 1'b0;
			end
		end
	end

	// ==========================================================
	// prescaler counter
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			pre_cnt_q <= DRTW_RST_RELOAD;
		end else if (wr_pre & direct) begin
			pre_cnt_q <= wdata;
		end else if (start) begin
			pre_cnt_q <= pre_rld_q;
		end else if (pre_step) begin
			if (pre_pend_q | pre_uf) begin
				pre_cnt_q <= pre_rld_n;
			end else begin
				pre_cnt_q <= pre_cnt_q - 8'h01;
			end
		end
	end

	// ==========================================================
	// timer counter
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			tmr_cnt_q <= DRTW_RST_RELOAD;
		end else if (wr_pri & direct) begin
			tmr_cnt_q <= wdata;
		end else if (start) begin
			tmr_cnt_q <= pri_rld_q;
		end else if (tmr_step) begin
			if (tmr_pend_q) begin
				tmr_cnt_q <= pri_rld_q;
			end else if (tmr_uf) begin
				tmr_cnt_q <= tmr_rld;
			end else begin
				tmr_cnt_q <= tmr_cnt_q - 8'h01;
			end
		end
	end

	// ==========================================================
	// waveform, source switch and interrupt
	wire          wave_d    = (state_d == DRTW_PRIMARY) & is_wave ? ~ols : ols;

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			wave_q <= 1'b0;
			oss_q  <= 1'b0;
			irq_q  <= 1'b0;
		end else begin
			wave_q <= wave_d;
			irq_q  <= irq_ev;
			if (start | irq_ev) begin
				oss_q <= io_q[DRTW_IO_OSS];
			end
		end
	end

	// ==========================================================
	// read path
	wire [7:0]    ctrl_rd   = {5'h00, 1'b0, running, running};
	wire [7:0]    rd_mux    = sel_ctrl ? ctrl_rd :
	                          sel_io   ? {4'h0, io_q[3:0]} :
	                          sel_mode ? mode_q :
	                          sel_pre  ? pre_cnt_q :
	                          sel_sec  ? (wave_run ? sec_buf_q : sec_rld_q) :
	                          sel_pri  ? tmr_cnt_q : 8'h00;

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= rd_en ? rd_mux : 8'h00;
		end
	end

	// ==========================================================
	// outputs
	assign rdata               = rdata_q;
	assign waveform_output_pin = oss_q ? port_output_latch : wave_q;
	assign waveform_output_oe  = is_wave;
	assign timer_irq           = irq_q;
	assign counting            = running;

endmodule : drtw_timer

// >>> drtw_timer_asserts.sv
`timescale 1ns/1ps
// ==========================================
// port checks for the timer block
module drtw_timer_asserts
	import drtw_pkg::*;
(
	input wire logic               core_clk,
	input wire logic               nrst,
	input wire logic [DRTW_AW-1:0] addr,
	input wire logic [DRTW_DW-1:0] wdata,
	input wire logic               wr_en,
	input wire logic               rd_en,
	input wire logic [DRTW_DW-1:0] rdata,
	input wire logic               upstream_uf,
	input wire logic               port_output_latch,
	input wire logic               waveform_output_pin,
	input wire logic               waveform_output_oe,
	input wire logic               timer_irq,
	input wire logic               counting
);
	logic [1:0] mode_q;
	logic [7:0] ioctl_q;
	logic       oss_q;
	logic       ols_prev_q;
	logic       cnt_prev_q;
	logic       oss_io_prev_q;
	wire        ctrl_wr = wr_en && addr == DRTW_OFS_CTRL;
	wire        run_wr  = ctrl_wr && wdata[DRTW_CTRL_RUN];
	wire        wave    = mode_q == DRTW_MODE_WAVE;
	// switch value in force: the irq cycle already shows the value latched one cycle earlier
	wire        oss_now = timer_irq ? oss_io_prev_q : oss_q;
	// ==========================================
	// shadow of mode, io control and latched switch
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			mode_q     <= 2'h0;
			ioctl_q    <= 8'h00;
			oss_q      <= 1'h0;
			ols_prev_q <= 1'h0;
			cnt_prev_q <= 1'h0;
			oss_io_prev_q <= 1'h0;
		end else begin
			if (wr_en && addr == DRTW_OFS_MODE)
				mode_q <= wdata[1:0];
			if (wr_en && addr == DRTW_OFS_IOCTL)
				ioctl_q <= wdata;
			if (run_wr && !wdata[DRTW_CTRL_HALT] && !counting)
				oss_q <= ioctl_q[DRTW_IO_OSS];
			else if (timer_irq)
				oss_q <= oss_io_prev_q;
			ols_prev_q <= ioctl_q[DRTW_IO_OLS];
			oss_io_prev_q <= ioctl_q[DRTW_IO_OSS];
			cnt_prev_q <= counting;
		end
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);
	sequence s_start_wr; run_wr && !wdata[DRTW_CTRL_HALT]; endsequence
	sequence s_stop_wr; ctrl_wr && (!wdata[DRTW_CTRL_RUN] || wdata[DRTW_CTRL_HALT]); endsequence
	sequence s_io_rd; rd_en && addr == DRTW_OFS_IOCTL; endsequence
	property p_start; s_start_wr |=> counting; endproperty
	property p_stop; s_stop_wr |=> !counting; endproperty
	property p_start_cause; $rose(counting) |-> $past(run_wr); endproperty
	property p_irq_run; timer_irq |-> $past(counting); endproperty
	property p_io_rd; s_io_rd |=> rdata[7:4] == 4'h0; endproperty
	property p_oe; waveform_output_oe == wave; endproperty
	property p_irq_pin; timer_irq && counting && wave && !oss_now |-> waveform_output_pin == !ols_prev_q; endproperty
	property p_stop_lvl; !counting && !cnt_prev_q && wave && !oss_now |-> waveform_output_pin == ols_prev_q; endproperty
	property p_oss; oss_now && wave |-> waveform_output_pin == port_output_latch; endproperty
	a_start: assert property (p_start) else $error("count did not start");
	a_stop: assert property (p_stop) else $error("count did not stop");
	a_start_cause: assert property (p_start_cause) else $error("count started without run write");
	a_irq_run: assert property (p_irq_run) else $error("irq while stopped");
	a_io_rd: assert property (p_io_rd) else $error("io control upper bits not zero");
	a_oe: assert property (p_oe) else $error("output enable wrong for mode");
	a_irq_pin: assert property (p_irq_pin) else $error("pin not at primary level with irq");
	a_stop_lvl: assert property (p_stop_lvl) else $error("stopped pin level wrong");
	a_oss: assert property (p_oss) else $error("pin does not follow port latch");
endmodule : drtw_timer_asserts

bind drtw_timer drtw_timer_asserts drtw_timer_asserts_i (.core_clk(core_clk), .nrst(nrst), .addr(addr),
	.wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .upstream_uf(upstream_uf),
	.port_output_latch(port_output_latch), .waveform_output_pin(waveform_output_pin),
	.waveform_output_oe(waveform_output_oe), .timer_irq(timer_irq), .counting(counting));

// >>> drtw_timer_tb_top.sv
`timescale 1ns/1ps
// ==========================================
// bench for the timer block
module drtw_timer_tb_top
	import drtw_pkg::*;
;
	logic               core_clk = 1'h0;
	logic               nrst = 1'h0;
	logic [DRTW_AW-1:0] addr = 16'h0000;
	logic [DRTW_DW-1:0] wdata = 8'h00;
	logic               wr_en = 1'h0;
	logic               rd_en = 1'h0;
	logic [DRTW_DW-1:0] rdata;
	logic               upstream_uf = 1'h0;
	logic               port_output_latch = 1'h0;
	logic               waveform_output_pin;
	logic               waveform_output_oe;
	logic               timer_irq;
	logic               counting;
	logic [1:0]         uc = 2'h0;
	int                 failures = 0;
	int                 samples_checked = 0;
	drtw_timer drtw_timer_i (.core_clk(core_clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
		.rd_en(rd_en), .rdata(rdata), .upstream_uf(upstream_uf), .port_output_latch(port_output_latch),
		.waveform_output_pin(waveform_output_pin), .waveform_output_oe(waveform_output_oe),
		.timer_irq(timer_irq), .counting(counting));
	always #2 core_clk = ~core_clk;
	// upstream underflow every third cycle
	always @(posedge core_clk) begin
		uc <= (uc == 2'h2) ? 2'h0 : uc + 2'h1;
		upstream_uf <= (uc == 2'h2);
	end
	// ==========================================
	// tasks
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		wr_en <= 1'h1;
		addr <= a;
		wdata <= d;
		@(posedge core_clk);
		wr_en <= 1'h0;
		@(posedge core_clk);
	endtask : wr
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		rd_en <= 1'h1;
		addr <= a;
		@(posedge core_clk);
		rd_en <= 1'h0;
		#1 d = rdata;
		@(posedge core_clk);
	endtask : rd
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// cycles between two irqs and pin-high cycles in that span
	task automatic meas(output int per, output int hi);
		int n;
		n = 0;
		per = 0;
		hi = 0;
		do begin
			@(posedge core_clk);
			#1 n++;
		end while (timer_irq !== 1'h1 && n < 3000);
		do begin
			hi += (waveform_output_pin === 1'h1);
			per++;
			@(posedge core_clk);
			#1;
		end while (timer_irq !== 1'h1 && per < 3000);
		if (n >= 3000 || per >= 3000)
			failures++;
	endtask : meas
	task automatic test_done;
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : test_done
	function automatic logic [7:0] mb(logic [1:0] src, logic wts, logic [1:0] md);
		return {2'h0, src, wts, 1'h0, md};
	endfunction : mb
	initial begin
		#100000;
		failures++;
		test_done();
	end
	// ==========================================
	// tests
	initial begin
		logic [15:0] ra [8] = '{16'h0108, 16'h0109, 16'h010A, 16'h010B, 16'h010C, 16'h010D, 16'h010E, 16'h0100};
		logic [7:0]  re [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'h00};
		logic [1:0]  srcs [4] = '{DRTW_SRC_F1, DRTW_SRC_F8, DRTW_SRC_UP, DRTW_SRC_F2};
		int          divs [4] = '{1, 8, 3, 2};
		int          wv [2][4] = '{'{0, 3, 1, 0}, '{1, 1, 2, 1}};
		logic [7:0]  v;
		logic [7:0]  a;
		int          per;
		int          hi;
		repeat (8) @(posedge core_clk);
		nrst <= 1'h1;
		@(posedge core_clk);
		for (int i = 0; i < 8; i++) begin
			rd(ra[i], v);
			chk("reset_value", v, re[i]);
		end
		wr(16'h0100, 8'h5A);
		rd(16'h0100, v);
		chk("unmapped", v, 8'h00);
		wr(DRTW_OFS_PRE, 8'h01);
		wr(DRTW_OFS_PRI, 8'h02);
		rd(DRTW_OFS_PRI, v);
		chk("stopped_write", v, 8'h02);
		wr(DRTW_OFS_IOCTL, 8'h00);
		for (int i = 0; i < 4; i++) begin
			wr(DRTW_OFS_MODE, mb(srcs[i], 1'h0, DRTW_MODE_TIMER));
			wr(DRTW_OFS_CTRL, 8'h01);
			rd(DRTW_OFS_CTRL, v);
			chk("ctrl_running", v, 8'h03);
			meas(per, hi);
			chk("timer_period", 8'(per), 8'(6 * divs[i]));
			wr(DRTW_OFS_CTRL, i[0] ? 8'h05 : 8'h00);
			rd(DRTW_OFS_CTRL, v);
			chk("stopped", counting, 1'h0);
			chk("stopped_ctrl", v, 8'h00);
		end
		for (int w = 0; w < 2; w++) begin
			wr(DRTW_OFS_MODE, mb(DRTW_SRC_F8, w[0], DRTW_MODE_TIMER));
			wr(DRTW_OFS_PRE, 8'h00);
			wr(DRTW_OFS_PRI, 8'hC8);
			wr(DRTW_OFS_CTRL, 8'h01);
			repeat (20) @(posedge core_clk);
			rd(DRTW_OFS_PRI, a);
			chk("live_count", a < 8'hC8, 1'h1);
			wr(DRTW_OFS_PRI, 8'h0A);
			repeat (20) @(posedge core_clk);
			rd(DRTW_OFS_PRI, v);
			chk("write_target", w[0] ? v > 8'h0A : v <= 8'h0A, 1'h1);
			wr(DRTW_OFS_CTRL, 8'h00);
		end
		wr(DRTW_OFS_MODE, mb(DRTW_SRC_F1, 1'h0, DRTW_MODE_WAVE));
		wr(DRTW_OFS_IOCTL, 8'hFF);
		rd(DRTW_OFS_IOCTL, v);
		chk("io_mask", v, 8'h0F);
		wr(DRTW_OFS_ONESHOT, 8'hFF);
		rd(DRTW_OFS_ONESHOT, v);
		chk("oneshot_ignored", v, 8'h00);
		for (int i = 0; i < 2; i++) begin
			wr(DRTW_OFS_CTRL, 8'h00);
			wr(DRTW_OFS_IOCTL, 8'(wv[i][3]));
			wr(DRTW_OFS_PRE, 8'(wv[i][0]));
			wr(DRTW_OFS_PRI, 8'(wv[i][1]));
			wr(DRTW_OFS_SEC, 8'(wv[i][2]));
			wr(DRTW_OFS_CTRL, 8'h01);
			meas(per, hi);
			chk("wave_period", 8'(per), 8'((wv[i][0] + 1) * (wv[i][1] + wv[i][2] + 2)));
			chk("wave_high", 8'(hi), 8'((wv[i][0] + 1) * (wv[i][3] ? wv[i][2] + 1 : wv[i][1] + 1)));
		end
		wr(DRTW_OFS_PRI, 8'h00);
		meas(per, hi);
		meas(per, hi);
		chk("running_write", 8'(per), 8'h08);
		wr(DRTW_OFS_CTRL, 8'h00);
		wr(DRTW_OFS_IOCTL, 8'h02);
		wr(DRTW_OFS_CTRL, 8'h01);
		for (int l = 0; l < 2; l++) begin
			port_output_latch <= l[0];
			repeat (2) @(posedge core_clk);
			chk("port_latch_out", waveform_output_pin, l[0]);
		end
		wr(DRTW_OFS_CTRL, 8'h00);
		test_done();
	end
endmodule : drtw_timer_tb_top
